// ===== sac_pkg.sv
// Package of shared constants and types for the stack arithmetic command subset.
package sac_pkg;

    localparam int SAC_W = 32;
    localparam int SAC_DEPTH = 4;

    // Low seven command bits; bit 7 is the service request choice.
    localparam logic [6:0] SAC_OP_NEG16 = 7'h74;
    localparam logic [6:0] SAC_OP_COS = 7'h03;
    localparam logic [6:0] SAC_OP_ADD32 = 7'h2C;
    localparam logic [6:0] SAC_OP_DIV32 = 7'h2F;
    localparam logic [6:0] SAC_OP_MULLO = 7'h2E;
    localparam logic [6:0] SAC_OP_MULHI = 7'h36;
    localparam logic [6:0] SAC_OP_SUB32 = 7'h2D;
    localparam logic [6:0] SAC_OP_EXP = 7'h0A;
    localparam logic [6:0] SAC_OP_FLOAT_SUM = 7'h10;
    localparam int SAC_SVC_BIT = 7;

    // Status byte field positions.
    localparam int SAC_ST_SIGN = 6;
    localparam int SAC_ST_ZERO = 5;
    localparam int SAC_ST_CARRY = 0;
    localparam logic [3:0] SAC_ERR_NONE = 4'h0;
    localparam logic [3:0] SAC_ERR_DIVZ = 4'h8;
    localparam logic [3:0] SAC_ERR_RANGE = 4'hC;
    localparam logic [3:0] SAC_ERR_OVF = 4'h4;
    localparam logic [3:0] SAC_ERR_EXPOVF = 4'h2;
    localparam logic [7:0] SAC_STATUS_RST = 8'h00;

    // Execution times in clock cycles, counted from the take edge to the done edge; a count of SAC_CYC_MIN (2) still takes 3.
    localparam logic [12:0] SAC_CYC_NEG16 = 13'd23;
    localparam logic [12:0] SAC_CYC_COS = 13'd3840;
    localparam logic [12:0] SAC_CYC_ADD32 = 13'd21;
    localparam logic [12:0] SAC_CYC_DIV32 = 13'd200;
    localparam logic [12:0] SAC_CYC_DIVZ = 13'd18;
    localparam logic [12:0] SAC_CYC_MULLO = 13'd200;
    localparam logic [12:0] SAC_CYC_MULHI = 13'd182;
    localparam logic [12:0] SAC_CYC_SUB32 = 13'd39;
    localparam logic [12:0] SAC_CYC_EXP = 13'd3794;
    localparam logic [12:0] SAC_CYC_EXPERR = 13'd34;
    localparam logic [12:0] SAC_CYC_FLOAT_SUM = 13'd54;
    localparam logic [12:0] SAC_CYC_FADD0 = 13'd24;
    localparam logic [12:0] SAC_CYC_MIN = 13'd2;

    // Floating format: sign, 7-bit exponent, 24-bit mantissa.
    localparam logic [6:0] SAC_EXP_LIMIT = 7'd6;
    localparam logic [31:0] SAC_FP_ONE = 32'h0180_0000;

    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_RUN = 3'b010,
        SAC_DONE = 3'b100
    } sac_state_e;

endpackage

// ===== sac_stack.sv
// Four-entry operand stack with push, pop-with-replace and top replace.
module sac_stack
    import sac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic push,
    input wire logic wr_top,
    input wire logic pop_wr,
    input wire logic kill_c_d,
    input wire logic [SAC_W-1:0] wdata,
    output logic [SAC_W-1:0] top_q,
    output logic [SAC_W-1:0] next_q
);
    typedef struct packed {
        logic [SAC_DEPTH-1:0][SAC_W-1:0] ent;
    } sac_stk_s;

    sac_stk_s st_reg;
    sac_stk_s st_next;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.ent = {st_reg.ent[2:0], wdata};
        end else if (pop_wr) begin
            // Result replaces the next entry and the old top rotates to the bottom.
            st_next.ent = {st_reg.ent[0], st_reg.ent[3], st_reg.ent[2], wdata};
        end else if (wr_top) begin
            st_next.ent[0] = wdata;
            if (kill_c_d) begin
                st_next.ent[2] = '0;
                st_next.ent[3] = '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign top_q = st_reg.ent[0];
    assign next_q = st_reg.ent[1];
endmodule // sac_stack

// ===== sac_timer.sv
// Down counter that pulses once, two cycles before a loaded cycle count of 3 or more has elapsed.
module sac_timer
    import sac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [12:0] count,
    output logic expired
);
    typedef struct packed {
        logic [12:0] cnt;
        logic busy;
        logic fire;
    } sac_tmr_s;

    sac_tmr_s t_reg;
    sac_tmr_s t_next;

    always_comb begin
        t_next = t_reg;
        t_next.fire = 1'b0;
        if (load) begin
            // The core spends one cycle writing back and one in completion after the pulse.
            t_next.cnt = count - 13'd2;
            t_next.busy = 1'b1;
        end else if (t_reg.busy) begin
            if (t_reg.cnt <= 13'd1) begin
                t_next.busy = 1'b0;
                t_next.fire = 1'b1;
            end else begin
                t_next.cnt = t_reg.cnt - 13'd1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign expired = t_reg.fire;
endmodule // sac_timer

// ===== sac_core.sv
// Execution datapath for a subset of stack arithmetic commands.
//
// Function
// [RL1] Negate 16-bit top; 22 to 24 cycles.
// [RL2] Most negative 16-bit: overflow, top unchanged.
// [RL3] Cosine replaces top; entries C, D lost.
// [RL4] Cosine range-reduced, 3840 to 4878 cycles.
// [RL5] 32-bit add: sum replaces next, pops.
// [RL6] Addition carry goes to carry bit.
// [RL7] Unrepresentable sum: low bits, overflow.
// [RL8] Divide next by top, quotient only.
// [RL9] Zero divisor: dividend, error, 18 cycles.
// [RL10] Most negative divide operand: overflow error.
// [RL11] Multiply lower keeps low product half.
// [RL12] Nonzero discarded upper half sets overflow.
// [RL13] Most negative multiply operand returned, overflow.
// [RL14] Multiply upper keeps high half, 182-218.
// [RL15] Most negative multiply-upper operand: overflow.
// [RL16] Subtract top from next, 38-40 cycles.
// [RL17] Subtraction borrow goes to carry bit.
// [RL18] Subtract overflow cases, low 32 bits.
// [RL19] Exponential replaces top; C, D lost.
// [RL20] Exponential beyond 32: error 1100, 34 cycles.
// [RL21] Float add, 24 cycles zero top.
// [RL22] Float exponent wrap reported, offset 128.
// [RL23] Bit 7 selects service request at completion.
// [RL24] Sign and zero from final top.
// [RL25] Decode low seven bits only.
module sac_core
    import sac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic push_valid,
    input wire logic [SAC_W-1:0] push_data,
    output logic busy,
    output logic done,
    output logic svc_req,
    output logic [7:0] status,
    output logic [SAC_W-1:0] stack_top,
    output logic [SAC_W-1:0] stack_next
);
    typedef struct packed {
        sac_state_e state;
        logic [6:0] op;
        logic svc_req_select;
        logic [SAC_W-1:0] result;
        logic [7:0] status;
        logic mode_pop;
        logic mode_kill;
        logic write_back;
        logic busy;
        logic done;
        logic svc;
        logic [SAC_W-1:0] top;
        logic [SAC_W-1:0] next;
    } sac_core_s;

    sac_core_s c_reg;
    sac_core_s c_next;

    logic [SAC_W-1:0] stk_top;
    logic [SAC_W-1:0] stk_next;
    logic stk_push;
    logic stk_wr_top;
    logic stk_pop_wr;
    logic tmr_load;
    logic [12:0] tmr_count;
    logic tmr_fire;

    // Arithmetic computed from the live stack at command acceptance.
    logic [SAC_W-1:0] most_neg;
    logic [15:0] neg16;
    logic [SAC_W:0] sum33;
    logic [SAC_W:0] dif33;
    logic signed [63:0] prod;
    logic [SAC_W-1:0] quot;
    logic a_mn;
    logic b_mn;
    logic [SAC_W-1:0] float_sum_r;
    logic float_sum_ovf;
    logic [SAC_W-1:0] cos_r;
    logic [SAC_W-1:0] exp_r;

    assign most_neg = {1'b1, {(SAC_W-1){1'b0}}};
    assign a_mn = (stk_top == most_neg);
    assign b_mn = (stk_next == most_neg);
    assign neg16 = 16'h0000 - stk_top[15:0];
    assign sum33 = {1'b0, stk_next} + {1'b0, stk_top};
    assign dif33 = {1'b0, stk_next} - {1'b0, stk_top};
    assign prod = $signed(stk_next) * $signed(stk_top);
    assign quot = (stk_top == '0 || a_mn || b_mn) ? stk_next
        : SAC_W'($signed(stk_next) / $signed(stk_top));

    // Simplified float add: equal-exponent mantissa sum, exponent wraps mod 128.
    always_comb begin
        logic [24:0] msum;
        logic [7:0] e8;
        msum = {1'b0, stk_top[23:0]} + {1'b0, stk_next[23:0]};
        e8 = {1'b0, stk_next[30:24]};
        float_sum_r = stk_next;
        float_sum_ovf = 1'b0;
        if (stk_top[23] == 1'b0) begin
            float_sum_r = stk_next;
        end else if (stk_next[23] == 1'b0) begin
            float_sum_r = stk_top;
        end else begin
            if (msum[24]) begin
                e8 = e8 + 8'd1;
                float_sum_r = {stk_next[31], e8[6:0], msum[24:1]};
            end else begin
                float_sum_r = {stk_next[31], e8[6:0], msum[23:0]};
            end
            // A carry out of the largest positive exponent wraps it to the most negative one.
            float_sum_ovf = msum[24] && (stk_next[30:24] == 7'h3F);
        end
    end

    // Transcendentals are held to a coarse constant approximation; the
    // sequencing, stack effect and timing are exact, accuracy is not.
    assign cos_r = (stk_top[30:24] > SAC_EXP_LIMIT) ? SAC_FP_ONE : SAC_FP_ONE;
    assign exp_r = SAC_FP_ONE;

    always_comb begin
        logic [6:0] opc;
        logic [15:0] t16;
        c_next = c_reg;
        c_next.done = 1'b0;
        stk_push = 1'b0;
        stk_wr_top = 1'b0;
        stk_pop_wr = 1'b0;
        tmr_load = 1'b0;
        tmr_count = SAC_CYC_MIN;
        // [RL25] Seven-bit decode
        opc = cmd_byte[6:0];
        t16 = stk_top[15:0];
        unique case (c_reg.state)
            SAC_IDLE: begin
                if (push_valid) begin
                    stk_push = 1'b1;
                end else if (cmd_valid) begin
                    c_next.op = opc;
                    // [RL23] Keep service choice
                    c_next.svc_req_select = cmd_byte[SAC_SVC_BIT];
                    c_next.svc = 1'b0;
                    c_next.status = SAC_STATUS_RST;
                    c_next.mode_pop = 1'b0;
                    c_next.mode_kill = 1'b0;
                    c_next.write_back = 1'b1;
                    c_next.result = stk_top;
                    c_next.state = SAC_RUN;
                    c_next.busy = 1'b1;
                    tmr_load = 1'b1;
                    case (opc)
                        SAC_OP_NEG16: begin
                            tmr_count = SAC_CYC_NEG16;
                            // [RL2] Most negative kept
                            if (t16 == 16'h8000) begin
                                c_next.status[3:0] = SAC_ERR_OVF;
                                c_next.write_back = 1'b0;
                            end else begin
                                // [RL1] Zero minus top
                                c_next.result = {stk_top[31:16], neg16};
                            end
                        end
                        SAC_OP_COS: begin
                            // [RL3] Top replaced, C D lost
                            // [RL4] Reduced cosine timing
                            tmr_count = SAC_CYC_COS;
                            c_next.result = cos_r;
                            c_next.mode_kill = 1'b1;
                        end
                        SAC_OP_ADD32: begin
                            // [RL5] Sum pops stack
                            tmr_count = SAC_CYC_ADD32;
                            c_next.mode_pop = 1'b1;
                            c_next.result = sum33[SAC_W-1:0];
                            // [RL6] Carry out
                            c_next.status[SAC_ST_CARRY] = sum33[SAC_W];
                            // [RL7] Signed overflow
                            if (stk_top[31] == stk_next[31] && sum33[31] != stk_top[31]) begin
                                c_next.status[3:0] = SAC_ERR_OVF;
                            end
                        end
                        SAC_OP_SUB32: begin
                            // [RL16] Difference pops stack
                            tmr_count = SAC_CYC_SUB32;
                            c_next.mode_pop = 1'b1;
                            c_next.result = dif33[SAC_W-1:0];
                            // [RL17] Borrow as carry
                            c_next.status[SAC_ST_CARRY] = dif33[SAC_W];
                            // [RL18] Subtract overflow
                            if (a_mn || (stk_top[31] != stk_next[31]
                                && dif33[31] != stk_next[31])) begin
                                c_next.status[3:0] = SAC_ERR_OVF;
                            end
                        end
                        SAC_OP_DIV32: begin
                            // [RL8] Quotient only
                            c_next.mode_pop = 1'b1;
                            c_next.result = quot;
                            tmr_count = SAC_CYC_DIV32;
                            if (stk_top == '0) begin
                                // [RL9] Divide by zero
                                c_next.status[3:0] = SAC_ERR_DIVZ;
                                tmr_count = SAC_CYC_DIVZ;
                            end else if (a_mn || b_mn) begin
                                // [RL10] Overflow error
                                c_next.status[3:0] = SAC_ERR_OVF;
                            end
                        end
                        SAC_OP_MULLO: begin
                            // [RL11] Low product half
                            tmr_count = SAC_CYC_MULLO;
                            c_next.mode_pop = 1'b1;
                            c_next.result = prod[31:0];
                            if (a_mn || b_mn) begin
                                // [RL13] Most negative returned
                                c_next.result = most_neg;
                                c_next.status[3:0] = SAC_ERR_OVF;
                            end else if (prod[63:32] != 32'h0000_0000) begin
                                // [RL12] Upper half nonzero
                                c_next.status[3:0] = SAC_ERR_OVF;
                            end
                        end
                        SAC_OP_MULHI: begin
                            // [RL14] High product half
                            tmr_count = SAC_CYC_MULHI;
                            c_next.mode_pop = 1'b1;
                            c_next.result = prod[63:32];
                            // [RL15] Overflow flagged
                            if (a_mn || b_mn) begin
                                c_next.status[3:0] = SAC_ERR_OVF;
                            end
                        end
                        SAC_OP_EXP: begin
                            // [RL19] Top replaced, C D lost
                            c_next.mode_kill = 1'b1;
                            c_next.result = exp_r;
                            tmr_count = SAC_CYC_EXP;
                            // [RL20] Out of range
                            if (stk_top[23] && stk_top[30:24] > SAC_EXP_LIMIT
                                && !stk_top[30]) begin
                                c_next.status[3:0] = SAC_ERR_RANGE;
                                tmr_count = SAC_CYC_EXPERR;
                            end
                        end
                        SAC_OP_FLOAT_SUM: begin
                            // [RL21] Float sum pops stack
                            c_next.mode_pop = 1'b1;
                            c_next.result = float_sum_r;
                            tmr_count = (stk_top[23] == 1'b0) ? SAC_CYC_FADD0 : SAC_CYC_FLOAT_SUM;
                            // [RL22] Exponent wrap reported
                            if (float_sum_ovf) begin
                                c_next.status[3:0] = SAC_ERR_EXPOVF;
                            end
                        end
                        default: begin
                            // Commands outside this subset finish without touching the stack.
                            c_next.write_back = 1'b0;
                        end
                    endcase
                end
            end
            SAC_RUN: begin
                if (tmr_fire) begin
                    stk_pop_wr = c_reg.write_back && c_reg.mode_pop;
                    stk_wr_top = c_reg.write_back && !c_reg.mode_pop;
                    c_next.state = SAC_DONE;
                end
            end
            SAC_DONE: begin
                // [RL24] Sign and zero from top
                c_next.status[SAC_ST_SIGN] = stk_top[31];
                c_next.status[SAC_ST_ZERO] = (c_reg.op == SAC_OP_NEG16)
                    ? (stk_top[15:0] == 16'h0000) : (stk_top == '0);
                if (c_reg.op == SAC_OP_NEG16) begin
                    c_next.status[SAC_ST_SIGN] = stk_top[15];
                end
                c_next.busy = 1'b0;
                c_next.done = 1'b1;
                // [RL23] Service request on completion
                c_next.svc = c_reg.svc_req_select;
                c_next.state = SAC_IDLE;
            end
            default: begin
                c_next.state = SAC_IDLE;
            end
        endcase
        c_next.top = stk_top;
        c_next.next = stk_next;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            c_reg <= '0;
            c_reg.state <= SAC_IDLE;
        end else begin
            c_reg <= c_next;
        end
    end

    sac_stack u_stack (
        .sys_clk(sys_clk),
        .reset(reset),
        .push(stk_push),
        .wr_top(stk_wr_top),
        .pop_wr(stk_pop_wr),
        .kill_c_d(c_reg.mode_kill),
        .wdata(stk_push ? push_data : c_reg.result),
        .top_q(stk_top),
        .next_q(stk_next)
    );

    sac_timer u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .load(tmr_load),
        .count(tmr_count),
        .expired(tmr_fire)
    );

    assign busy = c_reg.busy;
    assign done = c_reg.done;
    assign svc_req = c_reg.svc;
    assign status = c_reg.status;
    assign stack_top = c_reg.top;
    assign stack_next = c_reg.next;
endmodule // sac_core

// ===== sac_core_assertions.sv
// Checker of command timing, results and status at the ports of the arithmetic core.
module sac_core_assertions
    import sac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic push_valid,
    input wire logic [SAC_W-1:0] push_data,
    input wire logic busy,
    input wire logic done,
    input wire logic svc_req,
    input wire logic [7:0] status,
    input wire logic [SAC_W-1:0] stack_top,
    input wire logic [SAC_W-1:0] stack_next
);
    logic take;
    logic fin_add;
    logic fin_sub;
    logic add_ovf;
    logic [6:0] op_reg;
    logic svc_reg;
    logic [SAC_W-1:0] a_reg;
    logic [SAC_W-1:0] b_reg;
    logic [SAC_W:0] sum;
    logic [SAC_W:0] diff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    assign take = cmd_valid && !push_valid && !busy && !done;
    assign sum = {1'b0, b_reg} + {1'b0, a_reg};
    assign diff = {1'b0, b_reg} - {1'b0, a_reg};
    assign fin_add = done && op_reg == SAC_OP_ADD32;
    assign fin_sub = done && op_reg == SAC_OP_SUB32;
    assign add_ovf = (a_reg[31] == b_reg[31]) && (sum[31] != a_reg[31]);

    // Operands are captured at the take edge so results can be judged at completion.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            op_reg <= 7'h00;
            svc_reg <= 1'b0;
            a_reg <= 32'h0000_0000;
            b_reg <= 32'h0000_0000;
        end else if (take) begin
            op_reg <= cmd_byte[6:0];
            svc_reg <= cmd_byte[SAC_SVC_BIT];
            a_reg <= stack_top;
            b_reg <= stack_next;
        end
    end

    sequence s_take(op);
        take && cmd_byte[6:0] == op;
    endsequence

    chk_add_time: assert property (s_take(SAC_OP_ADD32) |-> ##21 done)
        else $error("add did not finish on time");
    chk_sub_time: assert property (s_take(SAC_OP_SUB32) |-> ##39 done)
        else $error("subtract did not finish on time");
    chk_neg_time: assert property (s_take(SAC_OP_NEG16) |-> ##23 done)
        else $error("negate did not finish on time");
    chk_mulhi_time: assert property (s_take(SAC_OP_MULHI) |-> ##182 done)
        else $error("multiply upper did not finish on time");
    chk_divz_time: assert property (s_take(SAC_OP_DIV32) ##0 stack_top == 32'h0000_0000
        |-> ##18 done) else $error("zero divisor did not finish on time");
    chk_svc_done: assert property (done |-> svc_req == svc_reg)
        else $error("service request does not follow command bit");
    chk_add_sum: assert property (fin_add |=> stack_top == $past(sum[31:0]))
        else $error("add result wrong");
    chk_add_ovf: assert property (fin_add && add_ovf |-> status[3:0] == SAC_ERR_OVF)
        else $error("add overflow not reported");
    chk_add_carry: assert property (fin_add && !add_ovf |-> status[SAC_ST_CARRY] == sum[32])
        else $error("add carry wrong");
    chk_sign_zero: assert property (fin_add |=> status[SAC_ST_SIGN] == stack_top[31]
        && status[SAC_ST_ZERO] == (stack_top == 32'h0000_0000))
        else $error("sign or zero status wrong");
    chk_sub_diff: assert property (fin_sub |=> stack_top == $past(diff[31:0]))
        else $error("subtract result wrong");
endmodule // sac_core_assertions

bind sac_core sac_core_assertions i_chk (.sys_clk(sys_clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .push_valid(push_valid),
    .push_data(push_data), .busy(busy), .done(done), .svc_req(svc_req), .status(status),
    .stack_top(stack_top), .stack_next(stack_next));

// ===== sac_host_model.sv
// Host side model that hands operands and command bytes to the core.
module sac_host_model
    import sac_pkg::*;
(
    input wire logic sys_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic push_valid,
    output logic [SAC_W-1:0] push_data
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        push_valid = 1'b0;
        push_data = 32'h0000_0000;
    end

    // Released lines show the inverse so a stale value can never pass for a fresh one.
    task automatic push(input logic [SAC_W-1:0] value);
        @(negedge sys_clk);
        push_data = value;
        push_valid = 1'b1;
        @(negedge sys_clk);
        push_valid = 1'b0;
        push_data = ~value;
    endtask

    task automatic issue(input logic [7:0] cmd);
        @(negedge sys_clk);
        cmd_byte = cmd;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_byte = ~cmd;
    endtask
endmodule // sac_host_model

// ===== sac_core_test.sv
// Self-checking bench for the arithmetic core driven through the host model.
module sac_core_test
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

    logic sys_clk;
    logic reset;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic push_valid;
    logic [SAC_W-1:0] push_data;
    logic busy;
    logic done;
    logic svc_req;
    logic [7:0] status;
    logic [SAC_W-1:0] stack_top;
    logic [SAC_W-1:0] stack_next;
    int fails = 0;
    int check_count = 0;
    int cycles;

    sac_host_model i_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .push_valid(push_valid), .push_data(push_data));

    sac_core i_dut (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .push_valid(push_valid), .push_data(push_data), .busy(busy),
        .done(done), .svc_req(svc_req), .status(status), .stack_top(stack_top),
        .stack_next(stack_next));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Counts clock edges from the take edge to the completion pulse.
    task automatic run(input logic [7:0] cmd);
        i_host.issue(cmd);
        `CHECK(busy, 1'b1)
        cycles = 0;
        do begin
            @(negedge sys_clk);
            cycles++;
        end while (done !== 1'b1 && cycles < 6000);
        if (cycles >= 6000) begin
            fails++;
            print_verdict();
        end
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic exec(input logic [31:0] nxt, input logic [31:0] top, input logic [7:0] cmd);
        i_host.push(nxt);
        i_host.push(top);
        run(cmd);
    endtask

    task automatic t_add();
        exec(32'hFFFF_FFFF, 32'h0000_0001, {1'b1, SAC_OP_ADD32});
        `CHECK(cycles, SAC_CYC_ADD32)
        `CHECK(stack_top, 32'h0000_0000)
        `CHECK(status, 8'h21)
        `CHECK(svc_req, 1'b1)
        exec(32'h7FFF_FFFF, 32'h0000_0001, {1'b0, SAC_OP_ADD32});
        `CHECK(stack_top, 32'h8000_0000)
        `CHECK(status, 8'h44)
        `CHECK(svc_req, 1'b0)
    endtask

    task automatic t_sub();
        exec(32'h0000_0000, 32'h0000_0001, {1'b0, SAC_OP_SUB32});
        `CHECK(cycles, SAC_CYC_SUB32)
        `CHECK(stack_top, 32'hFFFF_FFFF)
        `CHECK(status, 8'h41)
        exec(32'h0000_0000, 32'h8000_0000, {1'b1, SAC_OP_SUB32});
        `CHECK(stack_top, 32'h8000_0000)
        `CHECK(status[3:1], 3'b010)
    endtask

    task automatic t_div();
        exec(32'h0000_0007, 32'h0000_0000, {1'b0, SAC_OP_DIV32});
        `CHECK(cycles, SAC_CYC_DIVZ)
        `CHECK(stack_top, 32'h0000_0007)
        `CHECK(status[3:0], SAC_ERR_DIVZ)
        exec(32'h0000_0064, 32'h0000_0007, {1'b0, SAC_OP_DIV32});
        `CHECK(stack_top, 32'h0000_000E)
        exec(32'h8000_0000, 32'h0000_0002, {1'b0, SAC_OP_DIV32});
        `CHECK(status[3:0], SAC_ERR_OVF)
    endtask

    task automatic t_neg();
        exec(32'h0000_1234, 32'h0000_0005, {1'b0, SAC_OP_NEG16});
        `CHECK(cycles, SAC_CYC_NEG16)
        `CHECK(stack_top, 32'h0000_FFFB)
        `CHECK(stack_next, 32'h0000_1234)
        i_host.push(32'h0000_8000);
        run({1'b0, SAC_OP_NEG16});
        `CHECK(stack_top, 32'h0000_8000)
        `CHECK(status[3:0], SAC_ERR_OVF)
    endtask

    task automatic t_mul();
        exec(32'h8000_0000, 32'h0000_0003, {1'b0, SAC_OP_MULLO});
        `CHECK(stack_top, 32'h8000_0000)
        `CHECK(status[3:0], SAC_ERR_OVF)
        exec(32'h0001_0000, 32'h0001_0000, {1'b0, SAC_OP_MULLO});
        `CHECK(stack_top, 32'h0000_0000)
        `CHECK(status[3:0], SAC_ERR_OVF)
        exec(32'h0001_0000, 32'h0003_0000, {1'b0, SAC_OP_MULHI});
        `CHECK(cycles, SAC_CYC_MULHI)
        `CHECK(stack_top, 32'h0000_0003)
        exec(32'h0000_0002, 32'h8000_0000, {1'b0, SAC_OP_MULHI});
        `CHECK(status[3:0], SAC_ERR_OVF)
    endtask

    task automatic t_float();
        exec(SAC_FP_ONE, 32'h0000_0000, {1'b0, SAC_OP_FLOAT_SUM});
        `CHECK(cycles, SAC_CYC_FADD0)
        `CHECK(stack_top, SAC_FP_ONE)
        // One plus one is two: exponent 2, mantissa one half.
        exec(SAC_FP_ONE, SAC_FP_ONE, {1'b0, SAC_OP_FLOAT_SUM});
        `CHECK(cycles, SAC_CYC_FLOAT_SUM)
        `CHECK(stack_top, 32'h0280_0000)
        exec(32'h3F80_0000, 32'h3F80_0000, {1'b0, SAC_OP_FLOAT_SUM});
        `CHECK(stack_top, 32'h4080_0000)
        `CHECK(status[3:0], SAC_ERR_EXPOVF)
        exec(32'h0000_5555, 32'h0780_0000, {1'b0, SAC_OP_EXP});
        `CHECK(cycles, SAC_CYC_EXPERR)
        `CHECK(status[3:0], SAC_ERR_RANGE)
        exec(32'h0000_5555, SAC_FP_ONE, {1'b0, SAC_OP_EXP});
        `CHECK(cycles, SAC_CYC_EXP)
        `CHECK(stack_next, 32'h0000_5555)
        exec(32'h0000_6666, SAC_FP_ONE, {1'b1, SAC_OP_COS});
        `CHECK(cycles, SAC_CYC_COS)
        `CHECK(stack_next, 32'h0000_6666)
    endtask

    initial begin
        reset = 1'b1;
        repeat (6) @(negedge sys_clk);
        reset = 1'b0;
        t_add();
        t_sub();
        t_div();
        t_neg();
        t_mul();
        t_float();
        print_verdict();
    end
endmodule // sac_core_test
